// [rtl/plane_regs_pkg.sv]
// Constants, field layouts and carriers for the plane surface register bank.
// Assumes a single 20 MHz clock domain shared with the pipe timing strobes.
// How it works
// - Linear offset is the byte offset when linear; ignored when tiled.
// - Linear offset pending value goes active on vertical sync only.
// - First pixel address is surface base plus linear offset.
// - Writing surface base arms stride and base update at next vblank.
// - Key value holds red, green and blue bytes; top byte reserved.
// - Key registers act on pixels only while keying is enabled.
// - Key mask has same layout; zero mask bit ignores mismatch.
// - Flip source bit routes flip done to main or blitter streamer.
// - Tiled offset holds twelve bit y lines and x pixels.
// - Linear surfaces ignore tiled offset and pan by linear offset.
// - Tiled offset pending value goes active on vertical blank only.
// - Under rotation tiled x and y mark the lower right corner.
// - Live register reads the base address actually in use.
// - Plane B set updates at pipe vblank after trigger, else immediate.
// - Plane B start write triggers async flip and loads base.
// - Offsets accept software writes and command stream register loads.
// - Tiled control bit selects linear or tiled offset register.
// - Source key enable turns keying on for the plane.
package plane_regs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [19:0] OFS_A_LINEAR_OFFSET = 20'h70184;
  localparam logic [19:0] OFS_A_STRIDE = 20'h70188;
  localparam logic [19:0] OFS_A_KEY_VALUE = 20'h70194;
  localparam logic [19:0] OFS_A_KEY_MASK = 20'h70198;
  localparam logic [19:0] OFS_A_SURFACE_BASE = 20'h7019c;
  localparam logic [19:0] OFS_A_TILED_XY_OFFSET = 20'h701a4;
  localparam logic [19:0] OFS_A_LIVE_SURFACE_BASE = 20'h701ac;
  localparam logic [19:0] OFS_B_ASYNC_FLIP_START = 20'h7117c;
  // ==========================================================
  // Writable bit masks and field positions
  localparam logic [31:0] MASK_STRIDE = 32'hffffffc0;
  localparam logic [31:0] MASK_KEY = 32'h00ffffff;
  localparam logic [31:0] MASK_SURFACE = 32'hfffff008;
  localparam logic [31:0] MASK_TILED_XY = 32'h0fff0fff;
  localparam logic [31:0] MASK_B_START = 32'hfffff000;
  localparam int FLIP_SOURCE_BIT = 3;
  localparam int TILE_Y_LSB = 16;
  localparam int TILE_X_LSB = 0;
  localparam int TILE_FIELD_W = 12;
  localparam int KEY_CHAN_W = 8;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [11:0] y;
    logic [11:0] x;
  } tile_pos_t;
endpackage

// [rtl/color_key_match.sv]
// Per-pixel colour key comparator for the primary plane.
// Assumes key and mask come from the active register set of the bank.
module color_key_match
  import plane_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic key_enable_i,
  input wire logic [23:0] pixel_i,
  input wire logic [31:0] key_value_i,
  input wire logic [31:0] key_mask_i,
  output logic key_match_o
);
  typedef struct packed {
    logic match;
  } km_state_t;

  km_state_t s, next_s;
  logic [2:0] chan_ok;

  // ==========================================================
  // Comparison
  // Masked channel compare.
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      chan_ok[c] = ~|((pixel_i[c*KEY_CHAN_W +: KEY_CHAN_W] ^ key_value_i[c*KEY_CHAN_W +: KEY_CHAN_W])
                     & key_mask_i[c*KEY_CHAN_W +: KEY_CHAN_W]);
    end
    next_s = s;
    next_s.match = key_enable_i & (&chan_ok);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign key_match_o = s.match;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_key_off;
    !key_enable_i |=> !key_match_o;
  endproperty
  a_key_off: assert property (p_key_off) else $error("Key match raised while keying disabled.");

  property p_key_exact;
    key_enable_i && (pixel_i == key_value_i[23:0]) |=> key_match_o;
  endproperty
  a_key_exact: assert property (p_key_exact) else $error("Exact key pixel not matched.");
endmodule

// [rtl/plane_surface_regs.sv]
// Double-buffered surface address, stride, panning and colour key registers.
// Assumes vsync, vblank and flip done pulses are synchronous to sys_clk_i.
module plane_surface_regs
  import plane_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire reg_req_t mmio_req_i,
  input wire reg_req_t cs_req_i,
  output logic cs_ready_o,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic vsync_a_i,
  input wire logic vblank_a_i,
  input wire logic vblank_b_i,
  input wire logic pipe_b_enabled_i,
  input wire logic plane_b_enable_i,
  input wire logic tiled_surface_i,
  input wire logic rotate_180_i,
  input wire logic key_enable_i,
  input wire logic flip_done_i,
  input wire logic [23:0] pixel_i,
  output logic [31:0] surface_base_o,
  output logic [31:0] first_pixel_addr_o,
  output logic [31:0] stride_o,
  output tile_pos_t tile_pos_o,
  output logic tile_pos_lower_right_o,
  output logic flip_done_main_o,
  output logic flip_done_blitter_o,
  output logic [31:0] plane_b_base_o,
  output logic plane_b_async_flip_o,
  output logic key_match_o
);
  typedef struct packed {
    logic [31:0] a_lin_pend;
    logic [31:0] a_lin;
    logic [31:0] a_stride_pend;
    logic [31:0] a_stride;
    logic [31:0] a_base_pend;
    logic [31:0] a_base;
    logic a_arm;
    logic [31:0] a_keyval_pend;
    logic [31:0] a_keyval;
    logic [31:0] a_keymsk_pend;
    logic [31:0] a_keymsk;
    logic [31:0] a_tile_pend;
    logic [31:0] a_tile;
    logic [31:0] first_addr;
    logic [31:0] b_start_pend;
    logic [31:0] b_base;
    logic b_arm;
    logic b_en_q;
    logic b_flip;
    logic flip_main;
    logic flip_blit;
    logic [31:0] rdata;
    logic rvalid;
  } state_t;

  state_t s, next_s;
  reg_req_t req;

  // ==========================================================
  // Helpers
  function automatic logic hit(input reg_req_t r, input logic [19:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [31:0] first_addr(input logic tiled, input logic [31:0] base, input logic [31:0] lin);
    logic [31:0] b;
    b = {base[31:12], 12'h000};
    return tiled ? b : b + lin;
  endfunction

  // ==========================================================
  // Request arbitration
  // Software writes win; stream loads wait.
  assign cs_ready_o = !mmio_req_i.wr && !mmio_req_i.rd;
  always_comb begin
    req = mmio_req_i;
    if (!mmio_req_i.wr && !mmio_req_i.rd && cs_req_i.wr) begin
      req = cs_req_i;
      req.rd = 1'b0;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.b_flip = 1'b0;
    next_s.flip_main = 1'b0;
    next_s.flip_blit = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.b_en_q = plane_b_enable_i;
    if (vsync_a_i) begin
      next_s.a_lin = s.a_lin_pend;
    end
    if (hit(req, OFS_A_LINEAR_OFFSET)) begin
      next_s.a_lin_pend = req.wdata;
    end
    if (vblank_a_i) begin
      next_s.a_tile = s.a_tile_pend;
      next_s.a_keyval = s.a_keyval_pend;
      next_s.a_keymsk = s.a_keymsk_pend;
    end
    if (hit(req, OFS_A_TILED_XY_OFFSET)) begin
      next_s.a_tile_pend = req.wdata & MASK_TILED_XY;
    end
    if (hit(req, OFS_A_KEY_VALUE)) begin
      next_s.a_keyval_pend = req.wdata & MASK_KEY;
    end
    if (hit(req, OFS_A_KEY_MASK)) begin
      next_s.a_keymsk_pend = req.wdata & MASK_KEY;
    end
    if (hit(req, OFS_A_STRIDE)) begin
      next_s.a_stride_pend = req.wdata & MASK_STRIDE;
    end
    if (vblank_a_i && s.a_arm) begin
      next_s.a_base = s.a_base_pend;
      next_s.a_stride = s.a_stride_pend;
      next_s.a_arm = 1'b0;
    end
    if (hit(req, OFS_A_SURFACE_BASE)) begin
      next_s.a_base_pend = req.wdata & MASK_SURFACE;
      next_s.a_arm = 1'b1;
    end
    next_s.first_addr = first_addr(tiled_surface_i, next_s.a_base, next_s.a_lin);
    if (flip_done_i) begin
      next_s.flip_main = !s.a_base[FLIP_SOURCE_BIT];
      next_s.flip_blit = s.a_base[FLIP_SOURCE_BIT];
    end
    if (plane_b_enable_i && !s.b_en_q) begin
      next_s.b_arm = 1'b1;
    end
    if (s.b_arm && (vblank_b_i || !pipe_b_enabled_i)) begin
      next_s.b_base = s.b_start_pend;
      next_s.b_arm = 1'b0;
    end
    if (hit(req, OFS_B_ASYNC_FLIP_START)) begin
      next_s.b_start_pend = req.wdata & MASK_B_START;
      next_s.b_flip = 1'b1;
      if (!pipe_b_enabled_i) begin
        next_s.b_base = req.wdata & MASK_B_START;
        next_s.b_arm = 1'b0;
      end else begin
        next_s.b_arm = 1'b1;
      end
    end
    // Read-back of pending values; the live offset reads the active base.
    if (req.rd) begin
      next_s.rvalid = 1'b1;
      unique case (req.addr)
        OFS_A_LINEAR_OFFSET: next_s.rdata = s.a_lin_pend;
        OFS_A_STRIDE: next_s.rdata = s.a_stride_pend;
        OFS_A_KEY_VALUE: next_s.rdata = s.a_keyval_pend;
        OFS_A_KEY_MASK: next_s.rdata = s.a_keymsk_pend;
        OFS_A_SURFACE_BASE: next_s.rdata = s.a_base_pend;
        OFS_A_TILED_XY_OFFSET: next_s.rdata = s.a_tile_pend;
        OFS_A_LIVE_SURFACE_BASE: next_s.rdata = s.a_base;
        OFS_B_ASYNC_FLIP_START: next_s.rdata = s.b_start_pend;
        default: next_s.rdata = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = s.rdata;
  assign reg_rvalid_o = s.rvalid;
  assign surface_base_o = s.a_base;
  assign first_pixel_addr_o = s.first_addr;
  assign stride_o = s.a_stride;
  // Twelve bit x and y fields.
  assign tile_pos_o.y = tiled_surface_i ? s.a_tile[TILE_Y_LSB +: TILE_FIELD_W] : 12'h000;
  assign tile_pos_o.x = tiled_surface_i ? s.a_tile[TILE_X_LSB +: TILE_FIELD_W] : 12'h000;
  assign tile_pos_lower_right_o = tiled_surface_i & rotate_180_i;
  assign flip_done_main_o = s.flip_main;
  assign flip_done_blitter_o = s.flip_blit;
  assign plane_b_base_o = s.b_base;
  assign plane_b_async_flip_o = s.b_flip;

  // ==========================================================
  // Colour key
  // Source key enable.
  color_key_match u_key (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .key_enable_i(key_enable_i),
    .pixel_i(pixel_i),
    .key_value_i(s.a_keyval),
    .key_mask_i(s.a_keymsk),
    .key_match_o(key_match_o)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_lin_vsync;
    vsync_a_i |=> s.a_lin == $past(s.a_lin_pend);
  endproperty
  a_lin_vsync: assert property (p_lin_vsync) else $error("Linear offset missed vsync load.");

  property p_lin_hold;
    !vsync_a_i |=> $stable(s.a_lin);
  endproperty
  a_lin_hold: assert property (p_lin_hold) else $error("Linear offset changed outside vsync.");

  property p_tile_vblank;
    vblank_a_i |=> s.a_tile == $past(s.a_tile_pend);
  endproperty
  a_tile_vblank: assert property (p_tile_vblank) else $error("Tiled offset missed vblank load.");

  sequence s_base_write;
    hit(req, OFS_A_SURFACE_BASE) && !vblank_a_i;
  endsequence

  property p_tile_hold;
    !vblank_a_i |=> $stable(s.a_tile);
  endproperty
  a_tile_hold: assert property (p_tile_hold) else $error("Tiled offset changed outside vblank.");

  property p_base_trigger;
    vblank_a_i && s.a_arm |=> (s.a_base == $past(s.a_base_pend)) && (s.a_stride == $past(s.a_stride_pend));
  endproperty
  a_base_trigger: assert property (p_base_trigger) else $error("Armed base and stride not loaded.");

  property p_base_arm;
    s_base_write |=> s.a_arm;
  endproperty
  a_base_arm: assert property (p_base_arm) else $error("Base write did not arm update.");

  property p_no_trigger;
    !(vblank_a_i && s.a_arm) |=> $stable(s.a_base) && $stable(s.a_stride);
  endproperty
  a_no_trigger: assert property (p_no_trigger) else $error("Active base moved without trigger.");

  property p_live;
    req.rd && req.addr == OFS_A_LIVE_SURFACE_BASE |=> reg_rvalid_o && reg_rdata_o == $past(s.a_base);
  endproperty
  a_live: assert property (p_live) else $error("Live read not active base.");

  property p_route;
    flip_done_i |=> (flip_done_blitter_o == $past(s.a_base[FLIP_SOURCE_BIT])) && (flip_done_main_o != flip_done_blitter_o);
  endproperty
  a_route: assert property (p_route) else $error("Flip done routed to wrong streamer.");

  property p_flip_quiet;
    !flip_done_i |=> !flip_done_main_o && !flip_done_blitter_o;
  endproperty
  a_flip_quiet: assert property (p_flip_quiet) else $error("Flip done pulse without flip.");

  property p_first_addr;
    ##1 first_pixel_addr_o == (surface_base_o & MASK_B_START) + ($past(tiled_surface_i) ? RESET_WORD : s.a_lin);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("First pixel address wrong.");

  sequence s_b_single_write;
    hit(req, OFS_B_ASYNC_FLIP_START) ##1 !hit(req, OFS_B_ASYNC_FLIP_START);
  endsequence
  sequence s_b_pulse;
    plane_b_async_flip_o ##1 !plane_b_async_flip_o;
  endsequence

  property p_b_flip;
    s_b_single_write |-> s_b_pulse;
  endproperty
  a_b_flip: assert property (p_b_flip) else $error("Async flip pulse missing.");

  property p_b_immediate;
    hit(req, OFS_B_ASYNC_FLIP_START) && !pipe_b_enabled_i |=> plane_b_base_o == ($past(req.wdata) & MASK_B_START);
  endproperty
  a_b_immediate: assert property (p_b_immediate) else $error("Plane B not updated immediately.");

  property p_b_hold;
    !hit(req, OFS_B_ASYNC_FLIP_START) && !(s.b_arm && (vblank_b_i || !pipe_b_enabled_i)) |=> $stable(plane_b_base_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Plane B base moved without trigger.");

  property p_cs_block;
    mmio_req_i.wr || mmio_req_i.rd |-> !cs_ready_o;
  endproperty
  a_cs_block: assert property (p_cs_block) else $error("Stream load accepted during software access.");
endmodule

// [bench/cmd_stream_model.sv]
// Command stream model issuing load-register-immediate writes to the bank.
// Assumes the bank's ready flag and a shared clock; drives on falling edges.
module cmd_stream_model
  import plane_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic cs_ready_i,
  output reg_req_t cs_req_o,
  output logic stuck_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_req_o = '0;
    stuck_o = 1'b0;
  end

  // caller supplies aligned values in order.
  task automatic load(input logic [19:0] a, input logic [31:0] d, input int gap);
    int n;
    logic ok;
    repeat (gap) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    cs_req_o.wr = 1'b1;
    cs_req_o.addr = a;
    cs_req_o.wdata = d;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 8) begin
      @(posedge sys_clk_i);
      ok = (cs_ready_i === 1'b1);
      n++;
    end
    if (!ok) stuck_o = 1'b1;
    @(negedge sys_clk_i);
    cs_req_o.wr = 1'b0;
    cs_req_o.addr = ~a;
    cs_req_o.wdata = ~d;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the plane surface register bank.
// Assumes the command stream model is compiled first; inputs move on falling edges.
module tb
  import plane_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t mmio = '0;
  reg_req_t cs_req;
  logic vsync = 1'b0, vblank_a = 1'b0, vblank_b = 1'b0, flip_done = 1'b0;
  logic pipe_b_on = 1'b0, plane_b_en = 1'b0, tiled = 1'b0, rot = 1'b0, key_en = 1'b0;
  logic [23:0] pixel = '0;
  logic cs_ready, rvalid, lower_right, done_main, done_blit, b_flip, key_match, stuck;
  logic [31:0] rdata, base, first_addr, stride, b_base;
  tile_pos_t tile_pos;
  int error_cnt = 0;
  int checks_done = 0;

  initial forever #25 sys_clk = ~sys_clk;

  plane_surface_regs u_plane_surface_regs (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .mmio_req_i(mmio),
    .cs_req_i(cs_req), .cs_ready_o(cs_ready), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .vsync_a_i(vsync), .vblank_a_i(vblank_a), .vblank_b_i(vblank_b), .pipe_b_enabled_i(pipe_b_on),
    .plane_b_enable_i(plane_b_en), .tiled_surface_i(tiled), .rotate_180_i(rot), .key_enable_i(key_en),
    .flip_done_i(flip_done), .pixel_i(pixel), .surface_base_o(base), .first_pixel_addr_o(first_addr),
    .stride_o(stride), .tile_pos_o(tile_pos), .tile_pos_lower_right_o(lower_right),
    .flip_done_main_o(done_main), .flip_done_blitter_o(done_blit), .plane_b_base_o(b_base),
    .plane_b_async_flip_o(b_flip), .key_match_o(key_match));

  cmd_stream_model u_cmd_stream_model (.sys_clk_i(sys_clk), .cs_ready_i(cs_ready), .cs_req_o(cs_req),
    .stuck_o(stuck));

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    mmio.wr = 1'b1;
    mmio.addr = a;
    mmio.wdata = d;
    @(negedge sys_clk);
    mmio.wr = 1'b0;
    mmio.wdata = ~d;
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    int n;
    @(negedge sys_clk);
    mmio.rd = 1'b1;
    mmio.addr = a;
    @(negedge sys_clk);
    mmio.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    if (rvalid !== 1'b1) begin
      error_cnt++;
      conclude();
    end else begin
      chk(rdata, exp);
    end
  endtask

  task automatic pulse(input int s);
    @(negedge sys_clk);
    case (s)
      0: vsync = 1'b1;
      1: vblank_a = 1'b1;
      2: vblank_b = 1'b1;
      default: flip_done = 1'b1;
    endcase
    @(negedge sys_clk);
    {vsync, vblank_a, vblank_b, flip_done} = 4'h0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [19:0] ofs [9] = '{OFS_A_LINEAR_OFFSET, OFS_A_STRIDE, OFS_A_KEY_VALUE, OFS_A_KEY_MASK,
      OFS_A_SURFACE_BASE, OFS_A_TILED_XY_OFFSET, OFS_A_LIVE_SURFACE_BASE, OFS_B_ASYNC_FLIP_START, 20'h70190};
    foreach (ofs[i]) rd(ofs[i], RESET_WORD);
    $display("test reset done");
  endtask

  task automatic t_base();
    wr(OFS_A_STRIDE, 32'h0000207f);
    wr(OFS_A_SURFACE_BASE, 32'h12345fff);
    rd(OFS_A_SURFACE_BASE, 32'h12345008);
    rd(OFS_A_LIVE_SURFACE_BASE, 32'h0);
    pulse(0);
    chk(base, 32'h0);
    pulse(1);
    chk(stride, 32'h00002040);
    chk(base, 32'h12345008);
    wr(OFS_A_LIVE_SURFACE_BASE, 32'h0);
    rd(OFS_A_LIVE_SURFACE_BASE, 32'h12345008);
    pulse(3);
    chk({30'h0, done_main, done_blit}, 32'h1);
    wr(OFS_A_SURFACE_BASE, 32'h00400000);
    pulse(1);
    pulse(3);
    chk({30'h0, done_main, done_blit}, 32'h2);
    chk(stride, 32'h00002040);
    $display("test base done");
  endtask

  task automatic t_linear();
    u_cmd_stream_model.load(OFS_A_LINEAR_OFFSET, 32'h00000100, 3);
    pulse(1);
    chk(first_addr, 32'h00400000);
    pulse(0);
    chk(first_addr, 32'h00400100);
    tiled = 1'b1;
    @(negedge sys_clk);
    chk(first_addr, 32'h00400000);
    tiled = 1'b0;
    $display("test linear done");
  endtask

  task automatic t_tiled();
    u_cmd_stream_model.load(OFS_A_TILED_XY_OFFSET, 32'hfabcf123, 0);
    rd(OFS_A_TILED_XY_OFFSET, 32'h0abc0123);
    tiled = 1'b1;
    pulse(0);
    chk(32'(tile_pos), 32'h0);
    pulse(1);
    chk(32'(tile_pos), 32'h00abc123);
    rot = 1'b1;
    @(negedge sys_clk);
    chk(32'(lower_right), 32'h1);
    tiled = 1'b0;
    @(negedge sys_clk);
    chk(32'(tile_pos), 32'h0);
    chk(32'(lower_right), 32'h0);
    rot = 1'b0;
    chk(32'(stuck), 32'h0);
    $display("test tiled done");
  endtask

  task automatic t_key();
    wr(OFS_A_KEY_VALUE, 32'hff112233);
    rd(OFS_A_KEY_VALUE, 32'h00112233);
    wr(OFS_A_KEY_MASK, 32'hffff0f00);
    rd(OFS_A_KEY_MASK, 32'h00ff0f00);
    pulse(1);
    key_en = 1'b1;
    pixel = 24'h11523f;
    @(negedge sys_clk);
    chk(32'(key_match), 32'h1);
    pixel = 24'h10523f;
    @(negedge sys_clk);
    chk(32'(key_match), 32'h0);
    pixel = 24'h11523f;
    key_en = 1'b0;
    @(negedge sys_clk);
    chk(32'(key_match), 32'h0);
    $display("test key done");
  endtask

  task automatic t_plane_b();
    plane_b_en = 1'b1;
    wr(OFS_B_ASYNC_FLIP_START, 32'h0abcdfff);
    chk(b_base, 32'h0abcd000);
    chk(32'(b_flip), 32'h1);
    pipe_b_on = 1'b1;
    wr(OFS_B_ASYNC_FLIP_START, 32'h00300000);
    chk(32'(b_flip), 32'h1);
    pulse(1);
    chk(b_base, 32'h0abcd000);
    pulse(2);
    chk(b_base, 32'h00300000);
    $display("test plane b done");
  endtask

  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_base();
    t_linear();
    t_tiled();
    t_key();
    t_plane_b();
    conclude();
  end
endmodule
